// [verilog/phase_mode_controller.v]
// phase count, operating mode and slewing for a core rail and an auxiliary rail,
// feedback switch control for the core rail; apb slave for software.
// assumes power-state bits come from same-clock serial logic and
// sense-pin strap levels arrive as asynchronous comparator outputs.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "phase_mode_regs.vh"
module phase_mode_controller #(
  parameter VID_W = 8,
  parameter THR_W = 6
) (
  input wire mclk,
  input wire rst,
  input wire clk_en,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // strap levels: high when the sense pin is held at 5V
  input wire core_phase1_sense,
  input wire core_phase2_sense,
  input wire core_phase3_sense,
  input wire aux_phase1_sense,
  input wire aux_phase2_sense,
  // power-state bits, active low, per rail
  input wire power_state_bit_a,
  input wire power_state_bit_b,
  input wire aux_power_state_bit_a,
  input wire aux_power_state_bit_b,
  // overcurrent comparators on the current monitor pins
  input wire core_current_monitor,
  input wire aux_current_monitor,
  // phase-1 low-side timing and comparators, per rail
  input wire core_low_side_on,
  input wire core_zero_cross,
  input wire core_diode_cond,
  input wire aux_low_side_on,
  input wire aux_zero_cross,
  input wire aux_diode_cond,
  // power stage control
  output reg [2:0] core_phase_en,
  output reg [1:0] aux_phase_en,
  output reg core_diode_emulation_mode,
  output reg aux_diode_emulation_mode,
  output reg core_continuous_conduction_mode,
  output reg aux_continuous_conduction_mode,
  output reg [11:0] core_ocp_threshold_mv,
  output reg [11:0] aux_ocp_threshold_mv,
  output wire [VID_W-1:0] core_vid_dac,
  output wire [VID_W-1:0] aux_vid_dac,
  output reg feedback_switch_closed,
  output reg secondary_feedback_track,
  output wire core_low_side_off,
  output wire aux_low_side_off,
  output wire [THR_W-1:0] core_zero_threshold,
  output wire [THR_W-1:0] aux_zero_threshold
);

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for pin inputs

  wire [4:0] straps;
  wire [1:0] ocp_sync;
  wire [3:0] cmp_sync;

  level_sync #(.WIDTH(11)) pin_sync (
    .mclk(mclk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in({core_diode_cond, core_zero_cross, aux_diode_cond,
               aux_zero_cross, aux_current_monitor, core_current_monitor,
               aux_phase2_sense, aux_phase1_sense, core_phase3_sense,
               core_phase2_sense, core_phase1_sense}),
    .sync_out({cmp_sync, ocp_sync, straps})
  );

  ////////////////////////////////////////////////////////////////////////
  // strap capture after reset

  reg [8:0] settle_cnt;
  reg strapped;
  reg [1:0] core_cfg;
  reg [1:0] aux_cfg;

  always @(posedge mclk) begin
    if (rst) begin
      settle_cnt <= 9'h000;
      strapped <= 1'b0;
      core_cfg <= `CFG_OFF;
      aux_cfg <= `CFG_OFF;
    end else if (clk_en && !strapped) begin
      settle_cnt <= settle_cnt + 9'h001;
      // sampled once, held until the next reset
      if (settle_cnt == `STRAP_SETTLE_CYC - 1) begin
        strapped <= 1'b1;
        if (straps[0])
          core_cfg <= `CFG_OFF;
        else if (straps[2] && straps[1])
          core_cfg <= `CFG_ONE;
        else if (straps[2])
          core_cfg <= `CFG_TWO;
        else
          core_cfg <= `CFG_THREE;
        if (straps[3])
          aux_cfg <= `CFG_OFF;
        else if (straps[4])
          aux_cfg <= `CFG_ONE;
        else
          aux_cfg <= `CFG_TWO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase count and mode from configuration and power state

  reg [1:0] core_n;
  reg [1:0] aux_n;
  reg core_emul;
  reg aux_emul;

  always @* begin
    core_emul = 1'b0;
    aux_emul = 1'b0;
    // full count when bit a high, shed one on 01, one-phase emulation on 00
    if (core_cfg == `CFG_OFF)
      core_n = `CFG_OFF;
    else if (power_state_bit_a)
      core_n = core_cfg;
    else if (power_state_bit_b)
      core_n = (core_cfg == `CFG_ONE) ? `CFG_ONE : core_cfg - 2'b01;
    else begin
      core_n = `CFG_ONE;
      core_emul = 1'b1;
    end
    if (aux_cfg == `CFG_OFF)
      aux_n = `CFG_OFF;
    else if (aux_power_state_bit_a)
      aux_n = aux_cfg;
    else if (aux_power_state_bit_b)
      aux_n = `CFG_ONE;
    else begin
      aux_n = `CFG_ONE;
      aux_emul = 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      core_phase_en <= 3'b000;
      aux_phase_en <= 2'b00;
      core_diode_emulation_mode <= 1'b0;
      aux_diode_emulation_mode <= 1'b0;
      core_continuous_conduction_mode <= 1'b0;
      aux_continuous_conduction_mode <= 1'b0;
      feedback_switch_closed <= 1'b0;
      secondary_feedback_track <= 1'b0;
      core_ocp_threshold_mv <= `OCP_THRESHOLD_MV;
      aux_ocp_threshold_mv <= `OCP_THRESHOLD_MV;
    end else if (clk_en) begin
      core_phase_en <= {core_n == `CFG_THREE, core_n[1], core_n != 2'b00};
      aux_phase_en <= {aux_n[1], aux_n != 2'b00};
      core_diode_emulation_mode <= core_emul;
      aux_diode_emulation_mode <= aux_emul;
      core_continuous_conduction_mode <= (core_n != `CFG_OFF) && !core_emul;
      aux_continuous_conduction_mode <= (aux_n != `CFG_OFF) && !aux_emul;
      // switch only in two-phase core, closed in two-phase mode
      feedback_switch_closed <= (core_cfg == `CFG_TWO) && (core_n == `CFG_TWO);
      // keep the open capacitor following feedback
      secondary_feedback_track <= (core_cfg == `CFG_TWO) &&
                                  (core_n != `CFG_TWO);
      // same threshold whatever the configuration
      core_ocp_threshold_mv <= `OCP_THRESHOLD_MV;
      aux_ocp_threshold_mv <= `OCP_THRESHOLD_MV;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb registers

  reg [15:0] slew_div;
  reg [VID_W-1:0] core_vid;
  reg [VID_W-1:0] aux_vid;
  reg [1:0] ocp_flags;
  wire apb_wr = psel && penable && pwrite;
  wire apb_rd = psel && penable && !pwrite;
  wire [THR_W-1:0] thr_bus [0:1];

  always @(posedge mclk) begin
    if (rst) begin
      slew_div <= `SLEW_DIV_RST;
      core_vid <= `VID_RST;
      aux_vid <= `VID_RST;
      ocp_flags <= 2'b00;
    end else if (clk_en) begin
      if (apb_wr && paddr == `REG_SLEW_DIV)
        slew_div <= pwdata[15:0];
      if (apb_wr && paddr == `REG_CORE_VID)
        core_vid <= pwdata[VID_W-1:0];
      if (apb_wr && paddr == `REG_AUX_VID)
        aux_vid <= pwdata[VID_W-1:0];
      // write one to clear; a new trip in the same cycle wins
      if (apb_wr && paddr == `REG_OCP_FLAGS)
        ocp_flags <= (ocp_flags & ~pwdata[1:0]) | ocp_sync;
      else
        ocp_flags <= ocp_flags | ocp_sync;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `REG_SLEW_DIV: prdata[15:0] <= slew_div;
          `REG_CORE_VID: prdata[VID_W-1:0] <= core_vid;
          `REG_AUX_VID: prdata[VID_W-1:0] <= aux_vid;
          `REG_STATUS: begin
            prdata[`ST_CORE_CFG] <= core_cfg;
            prdata[`ST_AUX_CFG] <= aux_cfg;
            prdata[`ST_CORE_EN] <= core_phase_en;
            prdata[`ST_AUX_EN] <= aux_phase_en;
            prdata[`ST_CORE_EMUL] <= core_diode_emulation_mode;
            prdata[`ST_AUX_EMUL] <= aux_diode_emulation_mode;
            prdata[`ST_SW_CLOSED] <= feedback_switch_closed;
            prdata[`ST_SW_TRACK] <= secondary_feedback_track;
            prdata[`ST_STRAPPED] <= strapped;
          end
          `REG_OCP_FLAGS: prdata[1:0] <= ocp_flags;
          `REG_DAC: prdata[VID_W+15:0] <= {aux_vid_dac, 8'h00, core_vid_dac};
          `REG_THRESH: prdata[THR_W+15:0] <= {thr_bus[1], 10'h000,
                                                thr_bus[0]};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-rail voltage slewing and diode-emulation tuning

  wire [VID_W-1:0] vid_bus [0:1];
  wire [VID_W-1:0] dac_bus [0:1];
  wire [1:0] emul_bus;
  wire [1:0] ls_on_bus;
  wire [1:0] off_bus;

  assign vid_bus[0] = core_vid;
  assign vid_bus[1] = aux_vid;
  assign emul_bus = {aux_diode_emulation_mode, core_diode_emulation_mode};
  assign ls_on_bus = {aux_low_side_on, core_low_side_on};
  assign core_vid_dac = dac_bus[0];
  assign aux_vid_dac = dac_bus[1];
  assign core_low_side_off = off_bus[0];
  assign aux_low_side_off = off_bus[1];
  assign core_zero_threshold = thr_bus[0];
  assign aux_zero_threshold = thr_bus[1];

  genvar r;
  generate
    for (r = 0; r < 2; r = r + 1) begin : rail
      reg [VID_W-1:0] dac;
      reg [15:0] step_cnt;
      always @(posedge mclk) begin
        if (rst) begin
          dac <= `VID_RST;
          step_cnt <= 16'h0000;
        end else if (clk_en) begin
          if (vid_bus[r] > dac) begin
            // one code per slew_div + 1 cycles
            if (step_cnt >= slew_div) begin
              step_cnt <= 16'h0000;
              dac <= dac + {{(VID_W-1){1'b0}}, 1'b1};
            end else
              step_cnt <= step_cnt + 16'h0001;
          end else begin
            // target drops at once; load discharges output
            dac <= vid_bus[r];
            step_cnt <= 16'h0000;
          end
        end
      end
      assign dac_bus[r] = dac;

      body_diode_tuner #(.THR_W(THR_W)) tuner (
        .mclk(mclk),
        .rst(rst),
        .clk_en(clk_en),
        .emul_active(emul_bus[r]),
        .low_side_on(ls_on_bus[r]),
        .zero_cross(cmp_sync[2-2*r]),
        .diode_cond(cmp_sync[3-2*r]),
        .low_side_off(off_bus[r]),
        .threshold(thr_bus[r])
      );
    end
  endgenerate

endmodule

// [verilog/phase_mode_regs.vh]
// constants for the phase and mode controller: offsets, fields, timing
// assumes a 250 MHz mclk and a 32-bit apb register bus
`ifndef PHASE_MODE_REGS_VH
`define PHASE_MODE_REGS_VH

// register byte offsets
`define REG_SLEW_DIV 8'h00
`define REG_CORE_VID 8'h04
`define REG_AUX_VID 8'h08
`define REG_STATUS 8'h0C
`define REG_OCP_FLAGS 8'h10
`define REG_DAC 8'h14
`define REG_THRESH 8'h18

// reset values
`define SLEW_DIV_RST 16'h0040
`define VID_RST 8'h00
`define THRESH_RST 6'h20

// status fields
`define ST_CORE_CFG 1:0
`define ST_AUX_CFG 3:2
`define ST_CORE_EN 6:4
`define ST_AUX_EN 9:8
`define ST_CORE_EMUL 12
`define ST_AUX_EMUL 13
`define ST_SW_CLOSED 16
`define ST_SW_TRACK 17
`define ST_STRAPPED 31

// rail configurations, phases in use
`define CFG_OFF 2'b00
`define CFG_ONE 2'b01
`define CFG_TWO 2'b10
`define CFG_THREE 2'b11

// overcurrent threshold in millivolts
`define OCP_THRESHOLD_MV 12'h5DC

// timing
`define MCLK_PERIOD_NS 4
`define STRAP_SETTLE_NS 1000
`define STRAP_SETTLE_CYC (`STRAP_SETTLE_NS / `MCLK_PERIOD_NS)
`define DIODE_TARGET_NS 40
`define DIODE_TARGET_CYC (`DIODE_TARGET_NS / `MCLK_PERIOD_NS)
`define DIODE_WINDOW_CYC (4 * `DIODE_TARGET_CYC)

`endif

// [verilog/level_sync.v]
// two-flop synchroniser, one stage pair per bit
// assumes asynchronous level inputs and one clock domain
`timescale 1ns/10ps
module level_sync #(
  parameter WIDTH = 1
) (
  input wire mclk,
  input wire rst,
  input wire clk_en,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : bit_sync
      reg stage1;
      reg stage2;
      always @(posedge mclk) begin
        if (rst) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else if (clk_en) begin
          stage1 <= async_in[i];
          stage2 <= stage1;
        end
      end
      assign sync_out[i] = stage2;
    end
  endgenerate

endmodule

// [verilog/body_diode_tuner.v]
// low-side release and zero-cross threshold tuning for one phase
// assumes synchronised comparator inputs and a 250 MHz mclk
`timescale 1ns/10ps
`include "phase_mode_regs.vh"
module body_diode_tuner #(
  parameter THR_W = 6,
  parameter TARGET_CYC = `DIODE_TARGET_CYC,
  parameter WINDOW_CYC = `DIODE_WINDOW_CYC
) (
  input wire mclk,
  input wire rst,
  input wire clk_en,
  input wire emul_active,
  input wire low_side_on,
  input wire zero_cross,
  input wire diode_cond,
  output reg low_side_off,
  output reg [THR_W-1:0] threshold
);

  reg fired;
  reg measuring;
  reg [7:0] win_cnt;
  reg [7:0] cond_cnt;

  always @(posedge mclk) begin
    if (rst) begin
      low_side_off <= 1'b0;
      threshold <= `THRESH_RST;
      fired <= 1'b0;
      measuring <= 1'b0;
      win_cnt <= 8'h00;
      cond_cnt <= 8'h00;
    end else if (clk_en) begin
      low_side_off <= 1'b0;
      if (!low_side_on)
        fired <= 1'b0;
      // release low side once the comparator sees zero current
      if (emul_active && low_side_on && zero_cross && !fired) begin
        low_side_off <= 1'b1;
        fired <= 1'b1;
        measuring <= 1'b1;
        win_cnt <= 8'h00;
        cond_cnt <= 8'h00;
      end else if (measuring) begin
        // watch the phase node after release
        win_cnt <= win_cnt + 8'h01;
        if (diode_cond)
          cond_cnt <= cond_cnt + 8'h01;
        if (win_cnt == WINDOW_CYC[7:0] - 8'h01) begin
          measuring <= 1'b0;
          // one step per release toward the target
          if (cond_cnt > TARGET_CYC[7:0] && threshold != {THR_W{1'b0}})
            threshold <= threshold - {{(THR_W-1){1'b0}}, 1'b1};
          else if (cond_cnt < TARGET_CYC[7:0] &&
                   threshold != {THR_W{1'b1}})
            threshold <= threshold + {{(THR_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// [testbench/pmc_checker.sv]
// port assertions for the phase and mode controller
// assumes one mclk domain with synchronous active-high rst
`timescale 1ns/10ps
module pmc_checker #(
  parameter VID_W = 8,
  parameter THR_W = 6
) (
  input wire mclk,
  input wire rst,
  input wire power_state_bit_a,
  input wire power_state_bit_b,
  input wire core_low_side_on,
  input wire [2:0] core_phase_en,
  input wire [1:0] aux_phase_en,
  input wire core_diode_emulation_mode,
  input wire aux_diode_emulation_mode,
  input wire core_continuous_conduction_mode,
  input wire [11:0] core_ocp_threshold_mv,
  input wire [11:0] aux_ocp_threshold_mv,
  input wire [VID_W-1:0] core_vid_dac,
  input wire feedback_switch_closed,
  input wire secondary_feedback_track,
  input wire core_low_side_off
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////
  a_ocp_fixed: assert property (
    core_ocp_threshold_mv == 12'h5dc && aux_ocp_threshold_mv == 12'h5dc)
    else $error("ocp threshold moved");
  a_core_emul_one: assert property (
    core_diode_emulation_mode |-> core_phase_en == 3'h1 &&
    !core_continuous_conduction_mode)
    else $error("core emulation not one phase");
  a_aux_emul_one: assert property (
    aux_diode_emulation_mode |-> aux_phase_en == 2'h1)
    else $error("aux emulation not one phase");
  a_core_low_emul: assert property (
    !power_state_bit_a && !power_state_bit_b && core_phase_en[0] |=>
    core_diode_emulation_mode) else $error("core emulation missed");
  a_full_conduction: assert property (
    power_state_bit_a && core_phase_en[0] |=>
    core_continuous_conduction_mode && !core_diode_emulation_mode)
    else $error("core continuous mode missed");
  a_switch_closed: assert property (
    feedback_switch_closed |-> core_phase_en == 3'h3 &&
    !secondary_feedback_track) else $error("switch closed wrongly");
  a_track_open: assert property (
    secondary_feedback_track |-> core_phase_en == 3'h1)
    else $error("tracking wrongly");
  a_ls_cause: assert property (
    core_low_side_off |-> $past(core_low_side_on) ##1 !core_low_side_off)
    else $error("low side release wrong");
  a_dac_step: assert property (
    core_vid_dac > $past(core_vid_dac) |->
    core_vid_dac == $past(core_vid_dac) + 1'b1) else $error("dac jumped up");
endmodule

bind phase_mode_controller pmc_checker #(.VID_W(VID_W), .THR_W(THR_W))
  pmc_checker_i (.mclk, .rst, .power_state_bit_a, .power_state_bit_b,
  .core_low_side_on, .core_phase_en, .aux_phase_en,
  .core_diode_emulation_mode, .aux_diode_emulation_mode,
  .core_continuous_conduction_mode, .core_ocp_threshold_mv,
  .aux_ocp_threshold_mv, .core_vid_dac, .feedback_switch_closed,
  .secondary_feedback_track, .core_low_side_off);

// [testbench/power_stage_model.sv]
// one phase of the power stage: low-side timing and node comparators
// assumes mclk and a free-running 64-cycle switching period
`timescale 1ns/10ps
module power_stage_model (
  input wire mclk,
  input wire rst,
  input wire low_side_off,
  input wire [7:0] cond_cyc,
  output logic low_side_on = 1'b0,
  output logic zero_cross = 1'b0,
  output logic diode_cond
);
  logic [5:0] tick = '0;
  logic [7:0] left = '0;
  always @(posedge mclk) begin
    tick <= rst ? 6'h0 : tick + 6'h1;
    low_side_on <= !rst && tick < 6'h1e;
    // current reaches zero part way through low-side on-time
    zero_cross <= !rst && tick >= 6'h0a && tick < 6'h1e;
    if (rst)
      left <= '0;
    else if (low_side_off)
      left <= cond_cyc;
    else if (left != 8'h0)
      left <= left - 8'h1;
  end
  // body diode conducts for cond_cyc cycles after release
  assign diode_cond = left != 8'h0;
endmodule

// [testbench/phase_mode_controller_bench.sv]
// self-checking bench for the phase and mode controller
// assumes two power stage models on the low-side timing pins
`timescale 1ns/10ps
module phase_mode_controller_bench;
  logic mclk = 0, rst = 1, clk_en = 1, e;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = '0, core_vid_dac, aux_vid_dac, m;
  logic [31:0] pwdata = '0, prdata, r;
  logic [4:0] strap_bus = '0;
  wire core_phase1_sense, core_phase2_sense, core_phase3_sense;
  wire aux_phase1_sense, aux_phase2_sense;
  logic power_state_bit_a = 1, power_state_bit_b = 1;
  logic aux_power_state_bit_a = 1, aux_power_state_bit_b = 1;
  logic core_current_monitor = 0, aux_current_monitor = 0;
  logic core_low_side_on, core_zero_cross, core_diode_cond, core_low_side_off;
  logic aux_low_side_on, aux_zero_cross, aux_diode_cond, aux_low_side_off;
  logic [2:0] core_phase_en;
  logic [1:0] aux_phase_en, f;
  logic core_diode_emulation_mode, aux_diode_emulation_mode;
  logic core_continuous_conduction_mode, aux_continuous_conduction_mode;
  logic [11:0] core_ocp_threshold_mv, aux_ocp_threshold_mv;
  logic [5:0] core_zero_threshold, aux_zero_threshold;
  logic feedback_switch_closed, secondary_feedback_track;
  logic [3:0] v, mask;
  logic [4:0] straps [4] = '{5'h00, 5'h10, 5'h0e, 5'h05};
  int ccfg [4] = '{3, 0, 1, 2};
  int acfg [4] = '{2, 2, 0, 1};
  int err_total = 0, checks_done = 0, n, nc, na;
  assign {core_phase1_sense, core_phase2_sense, core_phase3_sense,
    aux_phase1_sense, aux_phase2_sense} = strap_bus;
  wire [4:0] core_mode = {core_diode_emulation_mode,
    core_continuous_conduction_mode, core_phase_en};
  wire [4:0] aux_mode = {aux_diode_emulation_mode,
    aux_continuous_conduction_mode, 1'b0, aux_phase_en};
  wire [1:0] switch_pair = {feedback_switch_closed, secondary_feedback_track};
  wire [23:0] ocp_pair = {core_ocp_threshold_mv, aux_ocp_threshold_mv};
  always #2 mclk = ~mclk;
  phase_mode_controller phase_mode_controller_i (.mclk, .rst, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .core_phase1_sense, .core_phase2_sense, .core_phase3_sense,
    .aux_phase1_sense, .aux_phase2_sense, .power_state_bit_a,
    .power_state_bit_b, .aux_power_state_bit_a, .aux_power_state_bit_b,
    .core_current_monitor, .aux_current_monitor, .core_low_side_on,
    .core_zero_cross, .core_diode_cond, .aux_low_side_on, .aux_zero_cross,
    .aux_diode_cond, .core_phase_en, .aux_phase_en,
    .core_diode_emulation_mode, .aux_diode_emulation_mode,
    .core_continuous_conduction_mode, .aux_continuous_conduction_mode,
    .core_ocp_threshold_mv, .aux_ocp_threshold_mv, .core_vid_dac,
    .aux_vid_dac, .feedback_switch_closed, .secondary_feedback_track,
    .core_low_side_off, .aux_low_side_off, .core_zero_threshold,
    .aux_zero_threshold);
  power_stage_model core_stage (.mclk, .rst, .low_side_off(core_low_side_off),
    .cond_cyc(8'h14), .low_side_on(core_low_side_on),
    .zero_cross(core_zero_cross), .diode_cond(core_diode_cond));
  power_stage_model aux_stage (.mclk, .rst, .low_side_off(aux_low_side_off),
    .cond_cyc(8'h02), .low_side_on(aux_low_side_on),
    .zero_cross(aux_zero_cross), .diode_cond(aux_diode_cond));
  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // {emulation, continuous, phase enables} for a rail of cfg phases
  function automatic logic [7:0] mode(input int cfg, input logic a, b);
    int p;
    p = (cfg == 0) ? 0 : a ? cfg : (b && cfg > 1) ? cfg - 1 : 1;
    if (p == 0) return 8'h00;
    return {3'h0, !a && !b, a || b, 3'(~(3'h7 << p))};
  endfunction
  task automatic wait_dac(input logic [7:0] t);
    n = 0;
    while (core_vid_dac !== t && n < 200) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic tune;
    nc = 0;
    na = 0;
    {power_state_bit_a, power_state_bit_b} <= 2'h0;
    {aux_power_state_bit_a, aux_power_state_bit_b} <= 2'h0;
    repeat (700) begin
      @(posedge mclk);
      if (core_low_side_off === 1'b1) begin
        check(core_zero_threshold, 32'h20 - nc);
        nc++;
      end
      if (aux_low_side_off === 1'b1) begin
        check(aux_zero_threshold, 32'h20 + na);
        na++;
      end
    end
    check({nc > 5, na > 5}, 2'h3);
  endtask
  task final_report;
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32));
    for (int k = 0; k < 4; k++) begin
      strap_bus <= straps[k];
      {power_state_bit_a, power_state_bit_b} <= 2'h3;
      {aux_power_state_bit_a, aux_power_state_bit_b} <= 2'h3;
      rst <= 1'b1;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      repeat (270) @(posedge mclk);
      // moved straps after capture
      strap_bus <= ~straps[k];
      apb(0, 8'h0c, '0, r, e);
      check({r[31], r[3:0]}, {1'b1, 2'(acfg[k]), 2'(ccfg[k])});
      check(ocp_pair, 24'h5d_c5dc);
      if (k == 3) tune();
      mask = 4'($urandom);
      for (int i = 0; i < 16; i++) begin
        v = 4'(i) ^ mask;
        {power_state_bit_a, power_state_bit_b} <= v[3:2];
        {aux_power_state_bit_a, aux_power_state_bit_b} <= v[1:0];
        repeat (2) @(posedge mclk);
        m = mode(ccfg[k], v[3], v[2]);
        check(core_mode, m);
        check(aux_mode, mode(acfg[k], v[1], v[0]));
        f = (ccfg[k] != 2) ? 2'h0 : (m[2:0] == 3'h3) ? 2'h2 : 2'h1;
        check(switch_pair, f);
      end
    end
    // leave core emulation so no release pulse is caught by a freeze
    {power_state_bit_a, power_state_bit_b} <= 2'h3;
    apb(0, 8'h00, '0, r, e);
    check(r, 32'h0000_0040);
    apb(1, 8'h00, 32'h0000_0003, r, e);
    apb(1, 8'h04, 32'h0000_0008, r, e);
    wait_dac(8'h02);
    wait_dac(8'h03);
    check(n, 4);
    wait_dac(8'h08);
    check(core_vid_dac, 8'h08);
    apb(1, 8'h04, 32'h0000_0001, r, e);
    repeat (2) @(posedge mclk);
    check(core_vid_dac, 8'h01);
    apb(0, 8'h14, '0, r, e);
    check(r, 32'h0000_0001);
    apb(0, 8'h1c, '0, r, e);
    check({e, r}, 33'h1_0000_0000);
    // a trip while frozen must leave no flag behind
    clk_en <= 1'b0;
    {core_current_monitor, aux_current_monitor} <= 2'h3;
    repeat (8) @(posedge mclk);
    {core_current_monitor, aux_current_monitor} <= 2'h0;
    clk_en <= 1'b1;
    apb(0, 8'h10, '0, r, e);
    check(r, 32'h0000_0000);
    {core_current_monitor, aux_current_monitor} <= 2'h3;
    repeat (4) @(posedge mclk);
    {core_current_monitor, aux_current_monitor} <= 2'h0;
    apb(0, 8'h10, '0, r, e);
    check(r, 32'h0000_0003);
    apb(1, 8'h10, 32'h0000_0001, r, e);
    apb(0, 8'h10, '0, r, e);
    check(r, 32'h0000_0002);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    final_report();
  end
endmodule
